// *** dv/tb_ugp_gpio_top.sv ***
// self-checking bench for the gpio and modem pin block
`timescale 1ns/1ps
`default_nettype none
module tb_ugp_gpio_top;
   import ugp_pkg::*;
   logic       sys_clk, arst_n, reg_wr, reg_rd, gpio_irq, soft_reset_pulse, seen;
   logic       terminal_ready_chan_a, terminal_ready_chan_b;
   logic       modem_irq_enable_a, modem_irq_enable_b, modem_irq_a, modem_irq_b;
   logic [2:0] modem_status_a, modem_status_b, modem_delta_a, modem_delta_b, dl;
   logic [6:0] rx_fill_count;
   ugp_addr_t  reg_addr;
   ugp_byte_t  reg_wdata, reg_rdata, gpio_in, gpio_out, gpio_oe_n, ext_drv, d, v, e, x;
   logic [31:0] seed = 32'h54AA;
   int         mismatches = 0, checked = 0, cyc = 0, b, p;

   ugp_gpio_top #(.FILL_W_P(7)) ugp_gpio_top_i (.*);
   ugp_pin_peer ugp_pin_peer_i (.*);

   always #25 sys_clk = ~sys_clk;

   function automatic ugp_byte_t rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic ugp_byte_t f_level(ugp_byte_t dd, ugp_byte_t vv, ugp_byte_t ee);
      return (dd & vv) | (~dd & ee);
   endfunction
   function automatic logic [2:0] f_status(ugp_byte_t ee, int bb);
      return {~ee[bb+2], ~ee[bb+3], ~ee[bb]};
   endfunction

   task report_and_stop;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string n, input ugp_byte_t s, input ugp_byte_t xp);
      checked++;
      if (s !== xp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, xp, s);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task wr(input ugp_addr_t a, input ugp_byte_t xw);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= xw;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input ugp_addr_t a, output ugp_byte_t xr);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 xr = reg_rdata;
   endtask
   task setp(input ugp_byte_t xs);
      @(posedge sys_clk);
      ext_drv <= xs;
   endtask

   // a hang counts as a mismatch
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         report_and_stop();
      end
   end

   initial
   begin
      sys_clk = 1'b0;
      arst_n = 1'b0;
      {reg_wr, reg_rd, reg_addr, reg_wdata, ext_drv, rx_fill_count} = '0;
      {terminal_ready_chan_a, terminal_ready_chan_b} = 2'b00;
      {modem_irq_enable_a, modem_irq_enable_b} = 2'b11;
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      tick(2);
      chk("oe_n", gpio_oe_n, 8'hFF);
      for (int k = 0; k < 3; k++)
      begin
         x = (k == 0) ? 8'h40 : (k == 1) ? 8'h00 : rnd() % 8'h41;
         @(posedge sys_clk) rx_fill_count <= x[6:0];
         rd(ADDR_RX_FILL, d);
         chk("fill", d, x);
      end
      for (int k = 1; k < 6; k++)
      begin
         rd(ugp_addr_t'((k == 5) ? 15 : k), d);
         chk("reset_reg", d, 8'h00);
      end
      $display("test reset done");
      for (int k = 0; k < 6; k++)
      begin
         d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : rnd();
         v = rnd();
         e = rnd();
         @(posedge sys_clk) {terminal_ready_chan_a, terminal_ready_chan_b} <= e[1:0];
         wr(ADDR_PIN_DIR, d);
         wr(ADDR_PIN_LEVEL, v);
         setp(e);
         tick(8);
         chk("oe_n", gpio_oe_n, ~d);
         chk("out", gpio_out & d, v & d);
         rd(ADDR_PIN_LEVEL, x);
         chk("level", x, f_level(d, v, e));
      end
      $display("test drive done");
      wr(ADDR_PIN_DIR, 8'h00);
      setp(8'h00);
      wr(ADDR_PIN_IEN, 8'h01);
      tick(8);
      rd(ADDR_PIN_LEVEL, x);
      setp(8'h02);
      tick(8);
      chk("irq_masked", gpio_irq, 0);
      setp(8'h03);
      tick(8);
      chk("irq_set", gpio_irq, 1);
      setp(8'h02);
      tick(8);
      chk("irq_revert", gpio_irq, 0);
      setp(8'h03);
      tick(8);
      rd(ADDR_PIN_LEVEL, x);
      chk("level", x, 8'h03);
      tick(3);
      chk("irq_read", gpio_irq, 0);
      $display("test unlatched done");
      wr(ADDR_PIN_CTL, 8'h01);
      wr(ADDR_PIN_IEN, 8'h04);
      setp(8'h07);
      tick(8);
      setp(8'h03);
      tick(8);
      chk("irq_hold", gpio_irq, 1);
      // pin 2 is low again here, so its bit can read back high only through the capture
      rd(ADDR_PIN_LEVEL, x);
      chk("captured", x, 8'h07);
      tick(3);
      chk("irq_read", gpio_irq, 0);
      rd(ADDR_PIN_LEVEL, x);
      chk("released", x, 8'h03);
      $display("test latched done");
      for (int ch = 0; ch < 2; ch++)
      begin
         b = ch ? 0 : 4;
         wr(ADDR_PIN_CTL, ch ? 8'h04 : 8'h02);
         wr(ADDR_PIN_DIR, 8'hFF);
         wr(ADDR_PIN_LEVEL, 8'h00);
         wr(ADDR_PIN_IEN, 8'hFF);
         e = rnd();
         @(posedge sys_clk) {terminal_ready_chan_a, terminal_ready_chan_b} <= e[1:0];
         setp(e);
         tick(8);
         rd(ADDR_PIN_LEVEL, x);
         // channel a terminal ready came from e[1], channel b from e[0]
         chk("dtr", {gpio_oe_n[b+1], gpio_out[b+1]}, {1'b0, ~e[ch ? 0 : 1]});
         chk("modem_oe", {gpio_oe_n[b+2 +: 2], gpio_oe_n[b]}, 3'h7);
         // all inputs, so only the modem gating keeps the change irq quiet
         wr(ADDR_PIN_DIR, 8'h00);
         tick(8);
         rd(ADDR_PIN_LEVEL, x);
         for (int j = 0; j < 4; j++)
         begin
            // last pass repeats set ready with the modem enable low
            p = (j == 1) ? 3 : (j == 2) ? 2 : 0;
            @(posedge sys_clk) {modem_irq_enable_a, modem_irq_enable_b} <= {2{j != 3}};
            e[b+p] = ~e[b+p];
            setp(e);
            seen = 1'b0;
            dl = 3'h0;
            repeat (10)
            begin
               @(posedge sys_clk);
               #1 seen |= ch ? modem_irq_b : modem_irq_a;
               dl |= ch ? modem_delta_b : modem_delta_a;
            end
            chk("modem_irq", seen, j != 3);
            chk("delta", dl, (p == 0) ? 3'h1 : (p == 3) ? 3'h2 : 3'h4);
            chk("gpio_irq", gpio_irq, 0);
            chk("status", ch ? modem_status_b : modem_status_a, f_status(e, b));
         end
      end
      $display("test modem done");
      wr(ADDR_PIN_CTL, 8'h07);
      rd(ADDR_PIN_CTL, x);
      chk("ctl", x, 8'h07);
      wr(ADDR_PIN_CTL, 8'h08);
      tick(3);
      chk("oe_n", gpio_oe_n, 8'hFF);
      chk("status", {modem_status_a, modem_status_b}, 6'h00);
      rd(ADDR_PIN_CTL, x);
      chk("ctl", x, 8'h00);
      rd(ADDR_PIN_IEN, x);
      chk("ien", x, 8'h00);
      $display("test soft reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire

// *** dv/ugp_gpio_sva.sv ***
// port assertions for the gpio and modem pin block
`timescale 1ns/1ps
`default_nettype none
module ugp_gpio_sva
   import ugp_pkg::*;
#(
   parameter int unsigned FILL_W_P = 7
) (
   input wire logic                sys_clk,
   input wire logic                arst_n,
   input wire ugp_pkg::ugp_addr_t  reg_addr,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire ugp_pkg::ugp_byte_t  reg_wdata,
   input wire ugp_pkg::ugp_byte_t  reg_rdata,
   input wire logic [FILL_W_P-1:0] rx_fill_count,
   input wire ugp_pkg::ugp_byte_t  gpio_in,
   input wire ugp_pkg::ugp_byte_t  gpio_out,
   input wire ugp_pkg::ugp_byte_t  gpio_oe_n,
   input wire logic                gpio_irq,
   input wire logic                terminal_ready_chan_a,
   input wire logic                terminal_ready_chan_b,
   input wire logic                modem_irq_enable_a,
   input wire logic                modem_irq_enable_b,
   input wire logic [2:0]          modem_status_a,
   input wire logic [2:0]          modem_status_b,
   input wire logic [2:0]          modem_delta_a,
   input wire logic [2:0]          modem_delta_b,
   input wire logic                modem_irq_a,
   input wire logic                modem_irq_b,
   input wire logic                soft_reset_pulse
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // mirrors of the host's writes, so checks need not peek inside
   logic [2:0] ctl_ff;
   ugp_byte_t  ien_ff;
   ugp_byte_t  dir_ff;
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n || (reg_wr && reg_addr == ADDR_PIN_CTL && reg_wdata[CTL_SRST]))
      begin
         ctl_ff <= 3'h0;
         ien_ff <= 8'h00;
         dir_ff <= 8'h00;
      end
      else if (reg_wr)
      begin
         if (reg_addr == ADDR_PIN_CTL)
            ctl_ff <= reg_wdata[2:0];
         if (reg_addr == ADDR_PIN_IEN)
            ien_ff <= reg_wdata;
         if (reg_addr == ADDR_PIN_DIR)
            dir_ff <= reg_wdata;
      end
   end
   sequence s_srst;
      reg_wr && reg_addr == ADDR_PIN_CTL && reg_wdata[CTL_SRST];
   endsequence
   sequence s_dir_b;
      reg_wr && reg_addr == ADDR_PIN_DIR && !ctl_ff[CTL_MODEM_B];
   endsequence
   sequence s_dtr_a_steady;
      (ctl_ff[CTL_MODEM_A] && $stable(terminal_ready_chan_a)) [*3];
   endsequence
   property p_fill;
      reg_rd && reg_addr == ADDR_RX_FILL |=> reg_rdata == ugp_byte_t'($past(rx_fill_count));
   endproperty
   property p_ctl_rd;
      reg_rd && reg_addr == ADDR_PIN_CTL |=> reg_rdata == {5'h00, $past(ctl_ff)};
   endproperty
   property p_srst_pulse;
      s_srst |=> soft_reset_pulse ##1 !soft_reset_pulse;
   endproperty
   property p_srst_pins;
      s_srst |-> ##2 gpio_oe_n == 8'hFF && gpio_out == 8'h00;
   endproperty
   property p_dir;
      s_dir_b |-> ##2 gpio_oe_n[3:0] == ~$past(reg_wdata[3:0], 2);
   endproperty
   property p_irq_cause;
      $rose(gpio_irq) |-> $past(ien_ff & ~dir_ff & ~{{4{ctl_ff[1]}}, {4{ctl_ff[2]}}}) != 8'h00;
   endproperty
   property p_plain_a;
      !ctl_ff[CTL_MODEM_A] && !$past(ctl_ff[CTL_MODEM_A]) |->
         modem_status_a == 3'h0 && modem_delta_a == 3'h0 && !modem_irq_a;
   endproperty
   property p_plain_b;
      !ctl_ff[CTL_MODEM_B] && !$past(ctl_ff[CTL_MODEM_B]) |->
         modem_status_b == 3'h0 && modem_delta_b == 3'h0 && !modem_irq_b;
   endproperty
   property p_dtr_a;
      s_dtr_a_steady |-> !gpio_oe_n[5] && gpio_out[5] == !terminal_ready_chan_a;
   endproperty
   property p_mirq;
      (|modem_delta_a) && modem_irq_enable_a && $past(modem_irq_enable_a) |-> ##[0:1] modem_irq_a;
   endproperty
   a_fill: assert property (p_fill) else $error("fill count read wrong");
   a_ctl_rd: assert property (p_ctl_rd) else $error("control read wrong");
   a_srst_pulse: assert property (p_srst_pulse) else $error("soft reset pulse wrong");
   a_srst_pins: assert property (p_srst_pins) else $error("pins not reset");
   a_dir: assert property (p_dir) else $error("direction not applied");
   a_irq_cause: assert property (p_irq_cause) else $error("irq without enable");
   a_plain_a: assert property (p_plain_a) else $error("modem status in plain mode");
   a_plain_b: assert property (p_plain_b) else $error("modem status b in plain mode");
   a_dtr_a: assert property (p_dtr_a) else $error("terminal ready pin wrong");
   a_mirq: assert property (p_mirq) else $error("modem irq missing");
endmodule
bind ugp_gpio_top ugp_gpio_sva #(.FILL_W_P(FILL_W_P)) ugp_gpio_sva_i (.*);
`default_nettype wire

// *** dv/ugp_pin_peer.sv ***
// pin-side peripheral model that resolves each pin from both drivers
`timescale 1ns/1ps
`default_nettype none
module ugp_pin_peer
   import ugp_pkg::*;
(
   input  wire ugp_pkg::ugp_byte_t ext_drv,
   input  wire ugp_pkg::ugp_byte_t gpio_out,
   input  wire ugp_pkg::ugp_byte_t gpio_oe_n,
   output ugp_pkg::ugp_byte_t      gpio_in
);
   // a pin the block drives shows its value, any other pin the peripheral's
   assign gpio_in = (gpio_oe_n & ext_drv) | (~gpio_oe_n & gpio_out);
endmodule
`default_nettype wire

// *** src/ugp_gpio_top.sv ***
// gpio and modem pin block with its register port
`timescale 1ns/1ps
`default_nettype none
module ugp_gpio_top
   import ugp_pkg::*;
#(
   parameter int unsigned FILL_W_P = ugp_pkg::FILL_W
) (
   input  wire logic                  sys_clk,
   input  wire logic                  arst_n,
   input  wire ugp_pkg::ugp_addr_t    reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire ugp_pkg::ugp_byte_t    reg_wdata,
   output ugp_pkg::ugp_byte_t         reg_rdata,
   input  wire logic [FILL_W_P-1:0]   rx_fill_count,
   input  wire ugp_pkg::ugp_byte_t    gpio_in,
   output ugp_pkg::ugp_byte_t         gpio_out,
   output ugp_pkg::ugp_byte_t         gpio_oe_n,
   output logic                       gpio_irq,
   input  wire logic                  terminal_ready_chan_a,
   input  wire logic                  terminal_ready_chan_b,
   input  wire logic                  modem_irq_enable_a,
   input  wire logic                  modem_irq_enable_b,
   output logic [2:0]                 modem_status_a,
   output logic [2:0]                 modem_status_b,
   output logic [2:0]                 modem_delta_a,
   output logic [2:0]                 modem_delta_b,
   output logic                       modem_irq_a,
   output logic                       modem_irq_b,
   output logic                       soft_reset_pulse
);
   if (FILL_W_P != FILL_W)
   begin : g_bad_fill
      $error("fill count must be seven bits wide");
   end

   typedef struct packed {
      ugp_byte_t        dir;
      ugp_byte_t        outv;
      ugp_byte_t        ien;
      logic [CTL_W-1:0] ctl;
      ugp_byte_t        rdata;
      ugp_byte_t        drv;
      ugp_byte_t        oe_n;
      logic             irq;
      logic [2:0]       msr_a;
      logic [2:0]       msr_b;
      logic [2:0]       dmsr_a;
      logic [2:0]       dmsr_b;
      logic             mirq_a;
      logic             mirq_b;
      logic             srst;
   } ugp_top_t;

   localparam ugp_top_t ST_RST = '{
      dir:    RST_DIR,
      outv:   RST_LEVEL,
      ien:    RST_IEN,
      ctl:    RST_CTL,
      rdata:  8'h00,
      drv:    8'h00,
      oe_n:   8'hFF,
      irq:    1'b0,
      msr_a:  3'h0,
      msr_b:  3'h0,
      dmsr_a: 3'h0,
      dmsr_b: 3'h0,
      mirq_a: 1'b0,
      mirq_b: 1'b0,
      srst:   1'b0
   };

   ugp_top_t  st_ff;
   ugp_top_t  nxt_st;

   ugp_byte_t pin_lvl;
   ugp_byte_t pin_chg;
   ugp_byte_t pin_flag;
   ugp_byte_t pin_rd;
   ugp_byte_t modem_pin;
   ugp_byte_t dtr_lvl;
   logic      rd_level;
   logic      wr_ctl;
   logic      sw_clr;

   ugp_pin_sync #(
      .W (NPIN)
   ) u_sync (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .pin_async (gpio_in),
      .pin_level (pin_lvl)
   );

   assign rd_level = reg_rd && (reg_addr == ADDR_PIN_LEVEL);
   assign wr_ctl   = reg_wr && (reg_addr == ADDR_PIN_CTL);
   assign sw_clr   = wr_ctl && reg_wdata[CTL_SRST];

   for (genvar i = 0; i < NPIN; i++)
   begin : g_cell
      ugp_pin_cell u_cell (
         .sys_clk  (sys_clk),
         .arst_n   (arst_n),
         .soft_clr (sw_clr),
         .lvl      (pin_lvl[i]),
         .latch_en (st_ff.ctl[CTL_LATCH]),
         .rd_clr   (rd_level),
         .chg      (pin_chg[i]),
         .flag     (pin_flag[i]),
         .rd_bit   (pin_rd[i])
      );
   end

   // which pins belong to an enabled modem group
   assign modem_pin = ({8{st_ff.ctl[CTL_MODEM_A]}} & MASK_GRP_A)
                    | ({8{st_ff.ctl[CTL_MODEM_B]}} & MASK_GRP_B);

   // terminal ready is active low on the pin
   assign dtr_lvl = ({8{~terminal_ready_chan_a}} & MASK_GRP_A)
                  | ({8{~terminal_ready_chan_b}} & MASK_GRP_B);

   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.srst = 1'b0;

      // register writes
      if (reg_wr)
      begin
         case (reg_addr)
            ADDR_PIN_DIR:
            begin
               nxt_st.dir = reg_wdata;
            end
            ADDR_PIN_LEVEL:
            begin
               nxt_st.outv = reg_wdata;
            end
            ADDR_PIN_IEN:
            begin
               nxt_st.ien = reg_wdata;
            end
            ADDR_PIN_CTL:
            begin
               // bits 7..3 are not stored and read back as zero
               nxt_st.ctl = reg_wdata[CTL_W-1:0];
            end
            default:
            begin
               nxt_st.ien = st_ff.ien;
            end
         endcase
      end

      // register reads; unmapped offsets return zero
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_RX_FILL:
            begin
               nxt_st.rdata = 8'(rx_fill_count);
            end
            ADDR_PIN_DIR:
            begin
               nxt_st.rdata = st_ff.dir;
            end
            ADDR_PIN_LEVEL:
            begin
               nxt_st.rdata = pin_rd;
            end
            ADDR_PIN_IEN:
            begin
               nxt_st.rdata = st_ff.ien;
            end
            ADDR_PIN_CTL:
            begin
               nxt_st.rdata = 8'(st_ff.ctl);
            end
            default:
            begin
               nxt_st.rdata = 8'h00;
            end
         endcase
      end

      // pin drive: plain pins follow direction and level, modem groups
      // make terminal ready an output and the other three inputs
      nxt_st.drv = (st_ff.outv & ~modem_pin)
                 | (dtr_lvl & modem_pin & MASK_DTR);
      nxt_st.oe_n = ~((st_ff.dir & ~modem_pin)
                    | (modem_pin & MASK_DTR));

      // change interrupt from input pins outside modem groups only
      nxt_st.irq = |(pin_flag & st_ff.ien & ~st_ff.dir & ~modem_pin);

      // modem status: {carrier, ring, set ready}, complemented pins
      if (st_ff.ctl[CTL_MODEM_A])
      begin
         nxt_st.msr_a  = ~{pin_lvl[GRP_A+OFS_CD], pin_lvl[GRP_A+OFS_RI],
                           pin_lvl[GRP_A+OFS_DSR]};
         nxt_st.dmsr_a = {pin_chg[GRP_A+OFS_CD], pin_chg[GRP_A+OFS_RI],
                          pin_chg[GRP_A+OFS_DSR]};
      end
      else
      begin
         nxt_st.msr_a  = 3'h0;
         nxt_st.dmsr_a = 3'h0;
      end
      if (st_ff.ctl[CTL_MODEM_B])
      begin
         nxt_st.msr_b  = ~{pin_lvl[GRP_B+OFS_CD], pin_lvl[GRP_B+OFS_RI],
                           pin_lvl[GRP_B+OFS_DSR]};
         nxt_st.dmsr_b = {pin_chg[GRP_B+OFS_CD], pin_chg[GRP_B+OFS_RI],
                          pin_chg[GRP_B+OFS_DSR]};
      end
      else
      begin
         nxt_st.msr_b  = 3'h0;
         nxt_st.dmsr_b = 3'h0;
      end
      nxt_st.mirq_a = modem_irq_enable_a && (|nxt_st.dmsr_a);
      nxt_st.mirq_b = modem_irq_enable_b && (|nxt_st.dmsr_b);

      // soft reset returns every register to reset and pulses the request;
      // the bit itself is never stored, so it always reads zero
      if (sw_clr)
      begin
         nxt_st      = ST_RST;
         nxt_st.srst = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_ff <= ST_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata        = st_ff.rdata;
   assign gpio_out         = st_ff.drv;
   assign gpio_oe_n        = st_ff.oe_n;
   assign gpio_irq         = st_ff.irq;
   assign modem_status_a   = st_ff.msr_a;
   assign modem_status_b   = st_ff.msr_b;
   assign modem_delta_a    = st_ff.dmsr_a;
   assign modem_delta_b    = st_ff.dmsr_b;
   assign modem_irq_a      = st_ff.mirq_a;
   assign modem_irq_b      = st_ff.mirq_b;
   assign soft_reset_pulse = st_ff.srst;
endmodule
`default_nettype wire

// *** src/ugp_pin_cell.sv ***
// per-pin change flag with optional capture of the new level
`timescale 1ns/1ps
`default_nettype none
module ugp_pin_cell (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic soft_clr,
   input  wire logic lvl,
   input  wire logic latch_en,
   input  wire logic rd_clr,
   output logic      chg,
   output logic      flag,
   output logic      rd_bit
);
   typedef struct packed {
      logic prev;
      logic base;
      logic flag;
      logic held;
   } ugp_cell_t;

   ugp_cell_t st_ff;
   ugp_cell_t nxt_st;

   assign chg = lvl ^ st_ff.prev;

   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.prev = lvl;
      // a change in the clearing cycle re-flags, so no event is lost
      nxt_st.flag = latch_en & (chg | (st_ff.flag & ~rd_clr));
      if (latch_en && chg && (!st_ff.flag || rd_clr))
      begin
         nxt_st.held = lvl;
      end
      if (rd_clr || !latch_en)
      begin
         nxt_st.base = rd_clr ? lvl : st_ff.base;
      end
      if (soft_clr)
      begin
         nxt_st.base = lvl;
         nxt_st.flag = 1'b0;
         nxt_st.held = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // unlatched flag is live: reverting to the level seen at the last read clears it
   assign flag   = latch_en ? st_ff.flag : (lvl ^ st_ff.base);
   assign rd_bit = (latch_en && st_ff.flag) ? st_ff.held : lvl;
endmodule
`default_nettype wire

// *** src/ugp_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ugp_pin_sync #(
   parameter int unsigned W = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] pin_async,
   output logic      [W-1:0] pin_level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } ugp_sync_t;

   ugp_sync_t st_ff;
   ugp_sync_t nxt_st;

   always_comb
   begin
      nxt_st    = st_ff;
      nxt_st.s1 = pin_async;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      // a bit moves only once stages two and three agree
      for (int i = 0; i < W; i++)
      begin
         if (st_ff.s2[i] == st_ff.s3[i])
         begin
            nxt_st.lvl[i] = st_ff.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign pin_level = st_ff.lvl;
endmodule
`default_nettype wire

// *** src/ugp_pkg.sv ***
// constants and types for the uart bridge gpio and modem pin block
// Overview of operation
// - fill count register shows receive fifo characters 0..64, bit 7 reads zero
// - direction bit n: zero makes pin n an input, one an output
// - reading pin level returns the present level of each pin, or its captured level while latched and flagged
// - output pins drive the written pin level bit; input pins ignore it
// - an input change interrupts only when its change enable bit is one
// - modem groups ignore change enables; modem status enable governs them
// - writing the soft reset bit resets everything and the bit reads zero
// - control bit 2 turns pins 3..0 into channel b modem lines
// - control bit 1 turns pins 7..4 into channel a modem lines
// - unlatched: change flags, pin level read clears, reverting clears too
// - latched: change flags and captures level, both held until pin level read
// - plain pins never show in modem status nor raise modem interrupts
// - plain pins never take the terminal ready level from modem control
// - modem pins show carrier, ring, set ready and drive terminal ready
// - modem pin changes raise the modem interrupt when its enable is set
// - direction, level and change enable registers do not touch modem pins
// - modem status bits are the complement of the active low pins
// - pin level bits of modem inputs need not match modem status
package ugp_pkg;
   localparam int unsigned NPIN = 8;
   typedef logic [3:0] ugp_addr_t;
   typedef logic [7:0] ugp_byte_t;

   localparam ugp_addr_t ADDR_RX_FILL   = 4'h0;
   localparam ugp_addr_t ADDR_PIN_DIR   = 4'h1;
   localparam ugp_addr_t ADDR_PIN_LEVEL = 4'h2;
   localparam ugp_addr_t ADDR_PIN_IEN   = 4'h3;
   localparam ugp_addr_t ADDR_PIN_CTL   = 4'h4;

   localparam int unsigned CTL_LATCH   = 0;
   localparam int unsigned CTL_MODEM_A = 1;
   localparam int unsigned CTL_MODEM_B = 2;
   localparam int unsigned CTL_SRST    = 3;
   localparam int unsigned CTL_W       = 3;

   localparam int unsigned GRP_A = 4;
   localparam int unsigned GRP_B = 0;
   localparam int unsigned OFS_DSR = 0;
   localparam int unsigned OFS_DTR = 1;
   localparam int unsigned OFS_CD  = 2;
   localparam int unsigned OFS_RI  = 3;

   localparam ugp_byte_t MASK_GRP_A = 8'hF0;
   localparam ugp_byte_t MASK_GRP_B = 8'h0F;
   localparam ugp_byte_t MASK_DTR   = 8'h22;

   localparam int unsigned FILL_W   = 7;
   localparam ugp_byte_t RST_DIR    = 8'h00;
   localparam ugp_byte_t RST_LEVEL  = 8'h00;
   localparam ugp_byte_t RST_IEN    = 8'h00;
   localparam logic [CTL_W-1:0] RST_CTL = 3'h0;
endpackage
